// ---- hdl/qaw_pkg.sv ----
// register map, field layout and frame constants of the watchdog and wake id bank
// assumes nothing beyond a sv-2012 compiler
package qaw_pkg;
  // register offsets on the serial link (7-bit address space)
  localparam logic [6:0] OFS_WD_SETUP    = 7'h2d;
  localparam logic [6:0] OFS_WD_REPLY    = 7'h2e;
  localparam logic [6:0] OFS_WD_PROMPT   = 7'h2f;
  localparam logic [6:0] OFS_IDENT_A     = 7'h30;
  localparam logic [6:0] OFS_IDENT_B     = 7'h31;
  localparam logic [6:0] OFS_IDENT_C     = 7'h32;
  localparam logic [6:0] OFS_IDENT_D     = 7'h33;
  localparam logic [6:0] OFS_FILTER_A    = 7'h34;
  localparam logic [6:0] OFS_FILTER_B    = 7'h35;
  localparam logic [6:0] OFS_FILTER_C    = 7'h36;
  localparam logic [6:0] OFS_OUT_PIN_CFG = 7'h29;

  // reset values, and the counter and challenge values shown when the watchdog is enabled
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [3:0] SEED_POWERUP    = 4'ha;
  localparam logic [1:0] REPLY_CNT_ON    = 2'h3;
  localparam logic [3:0] CHALLENGE_ON    = 4'hc;

  // field positions
  localparam int GEN_HI      = 7;
  localparam int GEN_LO      = 6;
  localparam int POLY_HI     = 5;
  localparam int POLY_LO     = 4;
  localparam int SEED_HI     = 3;
  localparam int SEED_LO     = 0;
  localparam int ERR_BIT     = 6;
  localparam int CNT_HI      = 5;
  localparam int CNT_LO      = 4;
  localparam int CHAL_HI     = 3;
  localparam int CHAL_LO     = 0;
  localparam int L10_HI      = 7;
  localparam int L10_LO      = 6;
  localparam int FMT_BIT     = 5;
  localparam int UPPER_HI    = 4;
  localparam int UPPER_LO    = 0;
  localparam int LOWER_HI    = 7;
  localparam int LOWER_LO    = 2;
  localparam int F1716_HI    = 1;
  localparam int F1716_LO    = 0;
  localparam int PIN_SEL_BIT = 0;

  // identifier widths
  localparam int STD_ID_W    = 11;
  localparam int EXT_ID_W    = 29;
  localparam int FILT_W      = 18;

  // serial frame: address byte, turnaround byte, data byte
  localparam logic [4:0] BIT_ADDR_LAST = 5'd7;
  localparam logic [4:0] BIT_DATA_FIRST = 5'd16;
  localparam logic [4:0] BIT_DATA_LAST = 5'd23;
  localparam int         SYNC_STAGES   = 3;
  localparam int         SYNC_W        = 3;
endpackage : qaw_pkg

// ---- hdl/qaw_link.sv ----
// serial-clock side of the register link: shifts frames in and read data out
// assumes mode 0 framing and a clock that only runs while chip select is low
`timescale 1ns/1ps
`default_nettype none
module qaw_link
  import qaw_pkg::*;
(
  // link pins
  input  wire logic       sclk,
  input  wire logic       chip_select_n,
  input  wire logic       mosi,
  input  wire logic       reset_n,
  output var  logic       sdo_ff,
  // handshake toward the core clock
  output var  logic [6:0] addr_ff,
  output var  logic       is_read_ff,
  output var  logic       rd_req_tgl_ff,
  input  wire logic       rd_ack_tgl,
  input  wire logic [7:0] rd_data,
  output var  logic [7:0] wr_data_ff,
  output var  logic       wr_req_tgl_ff
);
  logic [4:0] bit_cnt_ff;
  logic [6:0] in_sh_ff;
  logic [6:0] out_sh_ff;
  logic [SYNC_STAGES-1:0] ack_sy_ff;
  logic       ack_ok;

  // bit counter, cleared by the frame's own select
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_cnt_ff <= 5'd0;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 5'd1;
    end
  end

  // input shifter
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      in_sh_ff <= 7'd0;
    end else begin
      in_sh_ff <= {in_sh_ff[5:0], mosi};
    end
  end

  // address byte closes: latch and ask the core for readback
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_ff       <= 7'd0;
      is_read_ff    <= 1'b0;
      rd_req_tgl_ff <= 1'b0;
    end else if (!chip_select_n && bit_cnt_ff == BIT_ADDR_LAST) begin
      addr_ff       <= {in_sh_ff[5:0], mosi};
      is_read_ff    <= in_sh_ff[6];
      rd_req_tgl_ff <= ~rd_req_tgl_ff;
    end
  end

  // data byte closes: a write hands its byte to the core
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_data_ff    <= 8'd0;
      wr_req_tgl_ff <= 1'b0;
    end else if (!chip_select_n && bit_cnt_ff == BIT_DATA_LAST && !is_read_ff) begin
      wr_data_ff    <= {in_sh_ff, mosi};
      wr_req_tgl_ff <= ~wr_req_tgl_ff;
    end
  end

  // readback acknowledge crossing, counted once the last two stages agree
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_sy_ff <= '0;
    end else begin
      ack_sy_ff <= {ack_sy_ff[SYNC_STAGES-2:0], rd_ack_tgl};
    end
  end
  assign ack_ok = (ack_sy_ff[SYNC_STAGES-1] == ack_sy_ff[SYNC_STAGES-2])
               && (ack_sy_ff[SYNC_STAGES-1] == rd_req_tgl_ff);

  // output shifter on the falling edge, msb first
  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_ff    <= 1'b0;
      out_sh_ff <= 7'd0;
    end else if (bit_cnt_ff == BIT_DATA_FIRST) begin
      // data is only trusted once the core has answered
      sdo_ff    <= ack_ok ? rd_data[7] : 1'b0;
      out_sh_ff <= ack_ok ? rd_data[6:0] : 7'd0;
    end else begin
      sdo_ff    <= out_sh_ff[6];
      out_sh_ff <= {out_sh_ff[5:0], 1'b0};
    end
  end
endmodule // qaw_link
`default_nettype wire

// ---- hdl/qaw_regs.sv ----
// watchdog challenge and wake identifier register bank with serial-out pin sharing
// assumes a watchdog engine and a frame receiver on clk beside it, a host on the link
//
// How it works
// - select bit lets output pin carry interrupt
// - seed in bits 3:0, loaded in reset
// - seed reads zero, uses 1010 until written
// - reply generation and polynomial settings, read/write
// - wrong-reply flag set by hardware, write-one clears
// - reply counter read-only, shows 3 when enabled
// - challenge read-only, shows c when enabled
// - format bit picks 11 or 29 bit identifier
// - upper and lower base identifier bits placement
// - lower extended identifier bits placement
// - extended identifier filter bits placement
// - unused filter and identifier bits read zero
`timescale 1ns/1ps
`default_nettype none
module qaw_regs
  import qaw_pkg::*;
(
  // core clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  // serial link
  input  wire logic                sclk,
  input  wire logic                chip_select_n,
  input  wire logic                mosi,
  output var  logic                sdo_ff,
  output var  logic                out_pin_oe_ff,
  output var  logic                out_pin_irq_ff,
  output var  logic                irq_out_n_ff,
  // interrupt source from the rest of the device
  input  wire logic                irq_pending,
  // watchdog engine
  input  wire logic                wdog_in_reset_state,
  input  wire logic                wdog_enabled,
  input  wire logic                wdog_status_upd,
  input  wire logic [1:0]          wdog_reply_cnt,
  input  wire logic [3:0]          wdog_challenge,
  input  wire logic                wrong_reply_evt,
  output var  logic [1:0]          reply_generation_setting_ff,
  output var  logic [1:0]          challenge_polynomial_setting_ff,
  output var  logic [3:0]          challenge_seed_ff,
  output var  logic [7:0]          reply_byte_ff,
  output var  logic                reply_written_ff,
  // wake frame matching
  input  wire logic                rx_ident_valid,
  input  wire logic                rx_ident_long,
  input  wire logic [EXT_ID_W-1:0] rx_ident,
  output var  logic                ident_match_ff,
  output var  logic                ident_match_valid_ff
);
  logic             rst_s1_ff;
  logic             rst_n_core;
  logic [SYNC_W-1:0] sy1_ff;
  logic [SYNC_W-1:0] sy2_ff;
  logic [SYNC_W-1:0] sy3_ff;
  logic [SYNC_W-1:0] acc_ff;
  logic [SYNC_W-1:0] nxt_acc;
  logic             rd_evt;
  logic             wr_evt;
  logic             cs_n_core;
  logic [6:0]       link_addr;
  logic             link_is_read;
  logic             link_rd_tgl;
  logic [7:0]       link_wr_data;
  logic             link_wr_tgl;
  logic [7:0]       rd_hold_ff;
  logic             rd_ack_tgl_ff;
  logic [3:0]       seed_field_ff;
  logic             seed_written_ff;
  logic             wrong_reply_ff;
  logic [1:0]       reply_cnt_ff;
  logic [3:0]       challenge_ff;
  logic             wdog_en_d_ff;
  logic [1:0]       long_ident_1_0_ff;
  logic             long_format_ff;
  logic [4:0]       base_ident_upper_ff;
  logic [5:0]       base_ident_lower_ff;
  logic [7:0]       long_ident_17_10_ff;
  logic [7:0]       long_ident_9_2_ff;
  logic [1:0]       long_ident_filter_17_16_ff;
  logic [7:0]       long_ident_filter_15_8_ff;
  logic [7:0]       long_ident_filter_7_0_ff;
  logic             out_pin_shared_irq_sel_ff;
  logic [EXT_ID_W-1:0] full_ident;
  logic [EXT_ID_W-1:0] care_mask;
  logic [STD_ID_W-1:0] std_ident;
  logic             wr_to;
  logic [7:0]       wr_byte;

  // true when the address equals the given register offset
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    hit = (a == ofs);
  endfunction

  // readback image of one register
  function automatic logic [7:0] read_mux(input logic [6:0] a);
    logic [7:0] v;
    v = RST_BYTE;
    if (hit(a, OFS_WD_SETUP)) begin
      v = {reply_generation_setting_ff, challenge_polynomial_setting_ff, seed_field_ff};
    end else if (hit(a, OFS_WD_REPLY)) begin
      v = reply_byte_ff;
    end else if (hit(a, OFS_WD_PROMPT)) begin
      v = {1'b0, wrong_reply_ff, reply_cnt_ff, challenge_ff};
    end else if (hit(a, OFS_IDENT_A)) begin
      v = long_ident_17_10_ff;
    end else if (hit(a, OFS_IDENT_B)) begin
      v = long_ident_9_2_ff;
    end else if (hit(a, OFS_IDENT_C)) begin
      v = {long_ident_1_0_ff, long_format_ff, base_ident_upper_ff};
    end else if (hit(a, OFS_IDENT_D)) begin
      v = {base_ident_lower_ff, 2'b00};
    end else if (hit(a, OFS_FILTER_A)) begin
      v = {6'd0, long_ident_filter_17_16_ff};
    end else if (hit(a, OFS_FILTER_B)) begin
      v = long_ident_filter_15_8_ff;
    end else if (hit(a, OFS_FILTER_C)) begin
      v = long_ident_filter_7_0_ff;
    end else if (hit(a, OFS_OUT_PIN_CFG)) begin
      v = {7'd0, out_pin_shared_irq_sel_ff};
    end
    read_mux = v;
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_ff  <= 1'b0;
      rst_n_core <= 1'b0;
    end else begin
      rst_s1_ff  <= 1'b1;
      rst_n_core <= rst_s1_ff;
    end
  end

  // serial-clock side of the link
  qaw_link u_link (
    .sclk          (sclk),
    .chip_select_n (chip_select_n),
    .mosi          (mosi),
    .reset_n       (reset_n),
    .sdo_ff        (sdo_ff),
    .addr_ff       (link_addr),
    .is_read_ff    (link_is_read),
    .rd_req_tgl_ff (link_rd_tgl),
    .rd_ack_tgl    (rd_ack_tgl_ff),
    .rd_data       (rd_hold_ff),
    .wr_data_ff    (link_wr_data),
    .wr_req_tgl_ff (link_wr_tgl)
  );

  // three-flop crossing of select and both request toggles
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      sy1_ff <= 3'b001;
      sy2_ff <= 3'b001;
      sy3_ff <= 3'b001;
      acc_ff <= 3'b001;
    end else if (clk_en) begin
      sy1_ff <= {link_wr_tgl, link_rd_tgl, chip_select_n};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      acc_ff <= nxt_acc;
    end
  end

  // a change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      nxt_acc[i] = (sy2_ff[i] == sy3_ff[i]) ? sy3_ff[i] : acc_ff[i];
    end
  end

  assign cs_n_core = acc_ff[0];
  assign rd_evt    = clk_en && (nxt_acc[1] != acc_ff[1]);
  assign wr_evt    = clk_en && (nxt_acc[2] != acc_ff[2]);
  assign wr_byte   = link_wr_data;

  // write strobe: only write frames carry a data byte
  assign wr_to = wr_evt && !link_is_read;

  // readback snapshot and acknowledge
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      rd_hold_ff    <= RST_BYTE;
      rd_ack_tgl_ff <= 1'b0;
    end else if (rd_evt) begin
      rd_hold_ff    <= read_mux(link_addr);
      rd_ack_tgl_ff <= ~rd_ack_tgl_ff;
    end
  end

  // watchdog setup register
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      reply_generation_setting_ff     <= 2'b00;
      challenge_polynomial_setting_ff <= 2'b00;
      seed_field_ff                   <= 4'h0;
      seed_written_ff                 <= 1'b0;
    end else if (wr_to && hit(link_addr, OFS_WD_SETUP)) begin
      reply_generation_setting_ff     <= wr_byte[GEN_HI:GEN_LO];
      challenge_polynomial_setting_ff <= wr_byte[POLY_HI:POLY_LO];
      seed_field_ff                   <= wr_byte[SEED_HI:SEED_LO];
      seed_written_ff                 <= 1'b1;
    end
  end

  // seed in use, taken while the watchdog sits in reset
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      challenge_seed_ff <= SEED_POWERUP;
    end else if (clk_en && wdog_in_reset_state) begin
      challenge_seed_ff <= seed_written_ff ? seed_field_ff : SEED_POWERUP;
    end
  end

  // reply byte and its arrival pulse
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      reply_byte_ff    <= RST_BYTE;
      reply_written_ff <= 1'b0;
    end else if (clk_en) begin
      reply_written_ff <= wr_to && hit(link_addr, OFS_WD_REPLY);
      if (wr_to && hit(link_addr, OFS_WD_REPLY)) begin
        reply_byte_ff <= wr_byte;
      end
    end
  end

  // wrong-reply flag, a new event beats the clear
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      wrong_reply_ff <= 1'b0;
    end else if (clk_en) begin
      if (wrong_reply_evt) begin
        wrong_reply_ff <= 1'b1;
      end else if (wr_to && hit(link_addr, OFS_WD_PROMPT) && wr_byte[ERR_BIT]) begin
        wrong_reply_ff <= 1'b0;
      end
    end
  end

  // counter and challenge mirror of the engine
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      reply_cnt_ff <= 2'b00;
      challenge_ff <= 4'h0;
      wdog_en_d_ff <= 1'b0;
    end else if (clk_en) begin
      wdog_en_d_ff <= wdog_enabled;
      if (!wdog_enabled) begin
        reply_cnt_ff <= 2'b00;
        challenge_ff <= 4'h0;
      end else if (!wdog_en_d_ff) begin
        reply_cnt_ff <= REPLY_CNT_ON;
        challenge_ff <= CHALLENGE_ON;
      end else if (wdog_status_upd) begin
        reply_cnt_ff <= wdog_reply_cnt;
        challenge_ff <= wdog_challenge;
      end
    end
  end

  // wake identifier registers
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      long_ident_17_10_ff <= RST_BYTE;
      long_ident_9_2_ff   <= RST_BYTE;
      long_ident_1_0_ff   <= 2'b00;
      long_format_ff      <= 1'b0;
      base_ident_upper_ff <= 5'd0;
      base_ident_lower_ff <= 6'd0;
    end else if (wr_to) begin
      if (hit(link_addr, OFS_IDENT_A)) begin
        long_ident_17_10_ff <= wr_byte;
      end else if (hit(link_addr, OFS_IDENT_B)) begin
        long_ident_9_2_ff <= wr_byte;
      end else if (hit(link_addr, OFS_IDENT_C)) begin
        long_ident_1_0_ff   <= wr_byte[L10_HI:L10_LO];
        long_format_ff      <= wr_byte[FMT_BIT];
        base_ident_upper_ff <= wr_byte[UPPER_HI:UPPER_LO];
      end else if (hit(link_addr, OFS_IDENT_D)) begin
        base_ident_lower_ff <= wr_byte[LOWER_HI:LOWER_LO];
      end
    end
  end

  // wake identifier filter registers
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      long_ident_filter_17_16_ff <= 2'b00;
      long_ident_filter_15_8_ff  <= RST_BYTE;
      long_ident_filter_7_0_ff   <= RST_BYTE;
    end else if (wr_to) begin
      if (hit(link_addr, OFS_FILTER_A)) begin
        long_ident_filter_17_16_ff <= wr_byte[F1716_HI:F1716_LO];
      end else if (hit(link_addr, OFS_FILTER_B)) begin
        long_ident_filter_15_8_ff <= wr_byte;
      end else if (hit(link_addr, OFS_FILTER_C)) begin
        long_ident_filter_7_0_ff <= wr_byte;
      end
    end
  end

  // output pin function select
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      out_pin_shared_irq_sel_ff <= 1'b0;
    end else if (wr_to && hit(link_addr, OFS_OUT_PIN_CFG)) begin
      out_pin_shared_irq_sel_ff <= wr_byte[PIN_SEL_BIT];
    end
  end

  // pin sharing: read data while selected, interrupt while idle
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      out_pin_oe_ff  <= 1'b0;
      out_pin_irq_ff <= 1'b0;
      irq_out_n_ff   <= 1'b1;
    end else if (clk_en) begin
      out_pin_oe_ff  <= !cs_n_core || out_pin_shared_irq_sel_ff;
      out_pin_irq_ff <= cs_n_core && out_pin_shared_irq_sel_ff;
      irq_out_n_ff   <= !irq_pending;
    end
  end

  // identifier assembly and care mask
  assign full_ident = {base_ident_upper_ff, base_ident_lower_ff, long_ident_17_10_ff,
                       long_ident_9_2_ff, long_ident_1_0_ff};
  assign care_mask  = {{(EXT_ID_W-FILT_W){1'b1}}, ~{long_ident_filter_17_16_ff,
                       long_ident_filter_15_8_ff, long_ident_filter_7_0_ff}};
  assign std_ident  = {base_ident_upper_ff, base_ident_lower_ff};

  // wake frame identifier comparison
  always_ff @(posedge clk or negedge rst_n_core) begin
    if (!rst_n_core) begin
      ident_match_ff       <= 1'b0;
      ident_match_valid_ff <= 1'b0;
    end else if (clk_en) begin
      ident_match_valid_ff <= rx_ident_valid;
      if (rx_ident_valid) begin
        if (rx_ident_long != long_format_ff) begin
          ident_match_ff <= 1'b0;
        end else if (long_format_ff) begin
          ident_match_ff <= ((rx_ident ^ full_ident) & care_mask) == '0;
        end else begin
          ident_match_ff <= rx_ident[STD_ID_W-1:0] == std_ident;
        end
      end
    end
  end
endmodule // qaw_regs
`default_nettype wire

// ---- dv/qaw_host_model.sv ----
// host model: serial master that frames register reads and writes
// assumes mode 0 framing and a 32 ns link clock that stands still between frames
`timescale 1ns/1ps
`default_nettype none
module qaw_host_model (
  // link pins
  output var  logic sclk,
  output var  logic chip_select_n,
  output var  logic mosi,
  input  wire logic sdo
);
  // idle link: clock low, not selected
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end

  // one frame: command byte, turnaround byte, data byte, msb first
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] sh;
    sh = {rw, a, 8'h00, wd};
    #7 chip_select_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi = sh[i];
      #16 sclk = 1'b1;
      if (i < 8) rd[i] = sdo;
      #16 sclk = 1'b0;
    end
    #16 chip_select_n = 1'b1;
    mosi = ~mosi; // released line keeps no stale value
    #400; // room for the crossing before the next frame
  endtask
endmodule // qaw_host_model
`default_nettype wire

// ---- dv/qaw_regs_assertions.sv ----
// concurrent checks on the ports of the watchdog and wake id register bank
// assumes the bind below onto qaw_regs and the core clock clk
`timescale 1ns/1ps
`default_nettype none
module qaw_regs_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // pin sharing
  input wire logic       chip_select_n,
  input wire logic       irq_pending,
  input wire logic       irq_out_n_ff,
  input wire logic       out_pin_oe_ff,
  input wire logic       out_pin_irq_ff,
  // watchdog and matching
  input wire logic       wdog_in_reset_state,
  input wire logic [3:0] challenge_seed_ff,
  input wire logic [7:0] reply_byte_ff,
  input wire logic [1:0] reply_generation_setting_ff,
  input wire logic       reply_written_ff,
  input wire logic       rx_ident_valid,
  input wire logic       ident_match_valid_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // interrupt line follows the pending level
  property p_irq_low; irq_pending [*5] |-> !irq_out_n_ff; endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq line not low");
  property p_irq_high; !irq_pending [*5] |-> irq_out_n_ff; endproperty
  a_irq_high: assert property (p_irq_high) else $error("irq line not high");
  // pin shows interrupt only while driven and deselected
  property p_irq_oe; out_pin_irq_ff |-> out_pin_oe_ff; endproperty
  a_irq_oe: assert property (p_irq_oe) else $error("irq shown on undriven pin");
  property p_sel_data; !chip_select_n [*6] |-> !out_pin_irq_ff; endproperty
  a_sel_data: assert property (p_sel_data) else $error("irq shown while selected");
  property p_idle_irq; chip_select_n [*6] ##0 out_pin_oe_ff |-> out_pin_irq_ff; endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("irq missing while idle");
  // seed only moves while the watchdog sits in reset state
  property p_seed_hold; !wdog_in_reset_state [*2] |-> $stable(challenge_seed_ff); endproperty
  a_seed_hold: assert property (p_seed_hold) else $error("seed moved outside reset state");
  // reply write notice is a single pulse
  property p_reply_pulse; reply_written_ff |=> !reply_written_ff; endproperty
  a_reply_pulse: assert property (p_reply_pulse) else $error("reply notice too long");
  // settings hold while the link is quiet
  property p_cfg_hold; chip_select_n [*8] |-> $stable(reply_byte_ff) && $stable(reply_generation_setting_ff);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("setting changed without a frame");
  // match result one clock after each received identifier
  property p_match_lat; rx_ident_valid |=> ident_match_valid_ff ##0 $past(rx_ident_valid); endproperty
  a_match_lat: assert property (p_match_lat) else $error("match result late");
endmodule // qaw_regs_checker
`default_nettype wire

bind qaw_regs qaw_regs_checker u_chk (.clk(clk), .reset_n(reset_n), .chip_select_n(chip_select_n),
  .irq_pending(irq_pending), .irq_out_n_ff(irq_out_n_ff), .out_pin_oe_ff(out_pin_oe_ff),
  .out_pin_irq_ff(out_pin_irq_ff), .wdog_in_reset_state(wdog_in_reset_state),
  .challenge_seed_ff(challenge_seed_ff), .reply_byte_ff(reply_byte_ff),
  .reply_generation_setting_ff(reply_generation_setting_ff), .reply_written_ff(reply_written_ff),
  .rx_ident_valid(rx_ident_valid), .ident_match_valid_ff(ident_match_valid_ff));

// ---- dv/test_qaw_regs.sv ----
// self-checking bench for the watchdog and wake id register bank
// assumes qaw_regs, the host model and a 25 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module test_qaw_regs;
  import qaw_pkg::*;
  logic        clk, reset_n, clk_en, irq_pending, wdog_in_reset_state, wdog_enabled, wdog_status_upd;
  logic        wrong_reply_evt, rx_ident_valid, rx_ident_long, fm, lg;
  logic [1:0]  wdog_reply_cnt;
  logic [3:0]  wdog_challenge;
  logic [7:0]  v, rd_byte;
  logic [17:0] f;
  logic [28:0] rx_ident, r;
  wire         sclk, chip_select_n, mosi, sdo_ff, out_pin_oe_ff, out_pin_irq_ff, irq_out_n_ff, pad;
  wire         reply_written_ff, ident_match_ff, ident_match_valid_ff;
  wire  [1:0]  gen, poly;
  wire  [3:0]  seed;
  wire  [7:0]  reply;
  logic [6:0]  ofs [10];
  logic [7:0]  msk [10];
  logic [7:0]  exp_q [$];
  logic        exp_m [$];
  int          n_fail, compares;
  event        got;

  // device under test and the host on its link
  qaw_regs uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .sclk(sclk), .chip_select_n(chip_select_n),
    .mosi(mosi), .sdo_ff(sdo_ff), .out_pin_oe_ff(out_pin_oe_ff), .out_pin_irq_ff(out_pin_irq_ff),
    .irq_out_n_ff(irq_out_n_ff), .irq_pending(irq_pending), .wdog_in_reset_state(wdog_in_reset_state),
    .wdog_enabled(wdog_enabled), .wdog_status_upd(wdog_status_upd), .wdog_reply_cnt(wdog_reply_cnt),
    .wdog_challenge(wdog_challenge), .wrong_reply_evt(wrong_reply_evt), .reply_generation_setting_ff(gen),
    .challenge_polynomial_setting_ff(poly), .challenge_seed_ff(seed), .reply_byte_ff(reply),
    .reply_written_ff(reply_written_ff), .rx_ident_valid(rx_ident_valid), .rx_ident_long(rx_ident_long),
    .rx_ident(rx_ident), .ident_match_ff(ident_match_ff), .ident_match_valid_ff(ident_match_valid_ff));
  qaw_host_model host (.sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi), .sdo(pad));
  // pad mux outside the bank
  assign pad = out_pin_oe_ff ? (out_pin_irq_ff ? irq_out_n_ff : sdo_ff) : 1'bz;

  // core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b1, a, 8'h00, rd_byte);
    ->got;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, rd_byte);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  // expected wake match from the filter and format rules
  function automatic logic exp_match(input logic [28:0] rf, input logic [28:0] id, input logic [17:0] fl,
                                     input logic fmt, input logic lng);
    if (lng !== fmt) return 1'b0;
    if (lng) return ((rf ^ id) & ~{11'h000, fl}) == 29'h0;
    return rf[28:18] == id[10:0];
  endfunction

  // result watchers take the oldest note
  always @(got) chk("read byte", exp_q.pop_front(), rd_byte);
  always @(negedge clk) if (ident_match_valid_ff === 1'b1) chk("ident match", exp_m.pop_front(), ident_match_ff);

  // hang guard
  initial begin
    #300000 n_fail++;
    wrap_up;
  end

  initial begin
    {clk_en, wdog_in_reset_state} = 2'b11;
    {irq_pending, wdog_enabled, wdog_status_upd, wrong_reply_evt, rx_ident_valid, rx_ident_long} = '0;
    {rx_ident, wdog_reply_cnt, wdog_challenge, reset_n} = '0;
    ofs = '{OFS_OUT_PIN_CFG, OFS_WD_SETUP, OFS_WD_REPLY, OFS_IDENT_A, OFS_IDENT_B, OFS_IDENT_C, OFS_IDENT_D,
            OFS_FILTER_A, OFS_FILTER_B, OFS_FILTER_C};
    msk = '{8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfc, 8'h03, 8'hff, 8'hff};
    void'($urandom(22435));
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (6) @(negedge clk);
    chk("seed", 4'ha, seed);
    // reset values, unmapped place, random write and readback
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    rd(OFS_WD_PROMPT, 8'h00);
    wr(7'h2c, 8'h5a);
    rd(7'h2c, 8'h00);
    foreach (ofs[i]) begin
      v = $urandom;
      wr(ofs[i], v);
      rd(ofs[i], v & msk[i]);
    end
    // settings reach the watchdog, seed loaded in reset state
    wr(OFS_WD_SETUP, 8'h5b);
    wr(OFS_WD_REPLY, 8'ha7);
    chk("settings", {2'h1, 2'h1, 4'hb, 8'ha7}, {gen, poly, seed, reply});
    rd(OFS_WD_SETUP, 8'h5b);
    @(negedge clk) wdog_in_reset_state = 1'b0;
    // wrong-reply flag, read-only counter and challenge
    pulse(wrong_reply_evt);
    wr(OFS_WD_PROMPT, 8'hbf);
    rd(OFS_WD_PROMPT, 8'h40);
    wr(OFS_WD_PROMPT, 8'hff);
    rd(OFS_WD_PROMPT, 8'h00);
    @(negedge clk) clk_en = 1'b0;
    pulse(wrong_reply_evt);
    @(negedge clk) {clk_en, wdog_enabled} = 2'b11;
    rd(OFS_WD_PROMPT, 8'h3c);
    @(negedge clk) {wdog_reply_cnt, wdog_challenge} = 6'($urandom);
    pulse(wdog_status_upd);
    rd(OFS_WD_PROMPT, {2'b00, wdog_reply_cnt, wdog_challenge});
    // shared interrupt pin
    wr(OFS_OUT_PIN_CFG, 8'h01);
    @(negedge clk) irq_pending = 1'b1;
    repeat (8) @(negedge clk);
    chk("irq pin", 2'b10, {out_pin_irq_ff, irq_out_n_ff});
    rd(OFS_OUT_PIN_CFG, 8'h01);
    wr(OFS_OUT_PIN_CFG, 8'h00);
    repeat (8) @(negedge clk);
    chk("irq pin", 1'b0, out_pin_irq_ff);
    irq_pending = 1'b0;
    // wake identifier matching over both formats
    for (int k = 0; k < 16; k++) begin
      if (k % 4 == 0) begin
        r = 29'($urandom);
        f = 18'($urandom);
        fm = k[2];
        wr(OFS_IDENT_A, r[17:10]);
        wr(OFS_IDENT_B, r[9:2]);
        wr(OFS_IDENT_C, {r[1:0], fm, r[28:24]});
        wr(OFS_IDENT_D, {r[23:18], 2'b00});
        wr(OFS_FILTER_A, {6'h00, f[17:16]});
        wr(OFS_FILTER_B, f[15:8]);
        wr(OFS_FILTER_C, f[7:0]);
      end
      @(negedge clk);
      lg = (k[1:0] == 2'd3) ? ~fm : fm;
      rx_ident = (lg ? r : {18'h0, r[28:18]}) ^ (k[0] ? (29'h1 << ($urandom % 29)) : 29'h0);
      rx_ident_long = lg;
      exp_m.push_back(exp_match(r, rx_ident, f, fm, lg));
      rx_ident_valid = 1'b1;
      @(negedge clk) rx_ident_valid = 1'b0;
      repeat (3) @(negedge clk);
    end
    repeat (10) @(negedge clk);
    wrap_up;
  end
endmodule // test_qaw_regs
`default_nettype wire
